// File: design/rto_pkg.sv
// What this block does
// RULE_01: serial terminal clock runs at line rate
// RULE_02: serial data changes on terminal clock rise
// RULE_03: terminal samples serial data on falling edge
// RULE_04: nibble clock derived from recovered line clock
// RULE_05: nibble pulses per frame: 1176/1074/384
// RULE_06: nibble data changes on terminal clock fall
// RULE_07: terminal samples nibble on rising edge
// RULE_08: serial frame marker one bit period
// RULE_09: nibble frame marker one nibble period
// RULE_10: loop clock output sources transmit terminal timing
// RULE_11: terminal drives tx data on loop-clock rise
// RULE_12: tx serial captured on loop-clock rise
// RULE_13: loop clock is buffered line clock
// RULE_14: hdlc enabled puts byte bit 7 on loop pin
// RULE_15: serial output live only when nibble select low
// RULE_16: hdlc enabled puts byte bit 0 on nibble0
// RULE_17: frame marker changes with marked data
package rto_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_RATE_DS3_KHZ = 44736;
  localparam int LINE_RATE_E3_KHZ = 34368;

  // ----------------------------------------------------------------
  // framing of the nibble interface
  // ----------------------------------------------------------------
  localparam int NIB_BITS = 4;
  localparam int NIB_IDX_W = 11;
  localparam logic [NIB_IDX_W-1:0] NIB_PER_FRAME_DS3 = 11'h498;
  localparam logic [NIB_IDX_W-1:0] NIB_PER_FRAME_G832 = 11'h432;
  localparam logic [NIB_IDX_W-1:0] NIB_PER_FRAME_G751 = 11'h180;
  localparam logic [1:0] PHASE_LOAD = 2'h3;
  localparam logic [1:0] PHASE_CLK_HIGH = 2'h1;
  localparam int HDLC_NIB_BIT = 0;
  localparam int HDLC_LOOP_BIT = 7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTO_FMT_DS3,
    RTO_FMT_E3_G832,
    RTO_FMT_E3_G751
  } rto_fmt_e;

  typedef struct packed {
    logic data;
    logic first;
  } rto_bit_s;

  typedef struct packed {
    logic tclk;
    logic ser;
    logic [NIB_BITS-1:0] nib;
    logic frame;
    logic loop;
  } rto_pins_s;

  localparam rto_pins_s PINS_RST = '0;
  localparam logic [NIB_IDX_W-1:0] NIB_IDX_RST = 11'h000;
  localparam logic [1:0] PHASE_RST = 2'h0;

  function automatic logic [NIB_IDX_W-1:0] nib_limit(input rto_fmt_e fmt);
    case (fmt)
      RTO_FMT_DS3: nib_limit = NIB_PER_FRAME_DS3;
      RTO_FMT_E3_G832: nib_limit = NIB_PER_FRAME_G832;
      RTO_FMT_E3_G751: nib_limit = NIB_PER_FRAME_G751;
      default: nib_limit = NIB_PER_FRAME_DS3;
    endcase
  endfunction

endpackage

// File: design/rto_sync2.sv
`timescale 1ns/1ns
module rto_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock, // system clock
  input wire logic i_rst, // sync reset, high
  input wire logic [WIDTH-1:0] i_async, // pin level
  output logic [WIDTH-1:0] o_sync // synchronised level
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // rto_sync2

// File: design/rto_rx_terminal.sv
`timescale 1ns/1ns
module rto_rx_terminal
  import rto_pkg::*;
(
  input wire logic i_clock, // 100 MHz system clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_recovered_line_clock, // line clock pin
  input wire logic i_nibble_interface_select, // pin: 1 nibble, 0 serial
  input wire logic i_tx_serial_payload, // tx serial data pin
  input wire rto_fmt_e i_frame_format, // framing format config
  input wire logic i_loop_timing, // loop-timing mode enable
  input wire logic i_hdlc_enable, // hdlc controller on
  input wire logic [7:0] i_hdlc_byte, // received hdlc byte
  input wire rto_bit_s i_rx_in, // payload bit, valid on o_bit_take
  output logic o_bit_take, // takes i_rx_in this cycle
  output logic o_rx_terminal_clock, // terminal clock out
  output logic o_rx_serial_payload, // serial payload out
  output logic [NIB_BITS-1:0] o_rx_payload_nibble, // nibble out
  output logic o_rx_frame_boundary, // first bit/nibble marker
  output logic o_loop_timing_clock_out, // loop clock / hdlc bit 7
  output logic o_tx_bit, // captured tx bit
  output logic o_tx_bit_valid // pulse with o_tx_bit
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_sync;
  logic line_s;
  logic nib_s;
  logic tx_s;

  rto_sync2 #(.WIDTH(3)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_recovered_line_clock, i_nibble_interface_select, i_tx_serial_payload}),
    .o_sync(pin_sync)
  );

  assign line_s = pin_sync[2];
  assign nib_s = pin_sync[1];
  assign tx_s = pin_sync[0];

  // ----------------------------------------------------------------
  // edge detect and tx capture
  // ----------------------------------------------------------------
  logic line_d_r, line_d_nxt;
  logic tx_d_r, tx_d_nxt;
  logic tx_bit_r, tx_bit_nxt;
  logic tx_vld_r, tx_vld_nxt;
  logic rise;
  logic fall;

  assign rise = line_s & ~line_d_r;
  assign fall = ~line_s & line_d_r;
  assign o_bit_take = rise;

  // tx data moves on the terminal's rise, so take the value held
  // one cycle before the detected edge, not the racing one
  always_comb begin
    line_d_nxt = line_s;
    tx_d_nxt = tx_s;
    tx_bit_nxt = tx_bit_r;
    tx_vld_nxt = 1'b0;
    if (rise && i_loop_timing) begin
      tx_bit_nxt = tx_d_r; // RULE_12
      tx_vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      line_d_r <= 1'b0;
      tx_d_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tx_vld_r <= 1'b0;
    end else begin
      line_d_r <= line_d_nxt;
      tx_d_r <= tx_d_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_vld_r <= tx_vld_nxt;
    end
  end

  assign o_tx_bit = tx_bit_r;
  assign o_tx_bit_valid = tx_vld_r;

  // ----------------------------------------------------------------
  // nibble assembly and frame counting
  // ----------------------------------------------------------------
  logic [1:0] phase_r, phase_nxt;
  logic [NIB_IDX_W-1:0] idx_r, idx_nxt;
  logic [2:0] sh_r, sh_nxt;
  logic nib_d_r, nib_d_nxt;
  logic load;
  logic [NIB_IDX_W-1:0] limit;

  assign limit = nib_limit(i_frame_format);
  // a frame-start bit always opens a fresh nibble
  assign load = rise && nib_s && !i_rx_in.first && phase_r == PHASE_LOAD;

  always_comb begin
    phase_nxt = phase_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    nib_d_nxt = nib_s;
    if (nib_s != nib_d_r) begin
      phase_nxt = PHASE_RST;
      idx_nxt = NIB_IDX_RST;
    end else if (rise && nib_s) begin
      sh_nxt = {sh_r[1:0], i_rx_in.data};
      if (i_rx_in.first) begin
        phase_nxt = 2'h1;
        idx_nxt = NIB_IDX_RST;
      end else if (load) begin
        phase_nxt = PHASE_RST;
        // wrap keeps exactly limit pulses per frame
        idx_nxt = (idx_r >= limit - 11'h001) ? NIB_IDX_RST : idx_r + 11'h001; // RULE_05
      end else begin
        phase_nxt = phase_r + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_r <= PHASE_RST;
      idx_r <= NIB_IDX_RST;
      sh_r <= 3'h0;
      nib_d_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      nib_d_r <= nib_d_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  rto_pins_s pins_r, pins_nxt;
  logic [NIB_BITS-1:0] nib_raw_r, nib_raw_nxt;

  always_comb begin
    pins_nxt = pins_r;
    nib_raw_nxt = nib_raw_r;
    pins_nxt.loop = i_hdlc_enable ? i_hdlc_byte[HDLC_LOOP_BIT] : line_s; // RULE_10 RULE_13 RULE_14
    if (!nib_s) begin
      nib_raw_nxt = '0;
      pins_nxt.tclk = line_s; // RULE_01
      if (rise) begin
        pins_nxt.ser = i_rx_in.data; // RULE_02 RULE_15
        pins_nxt.frame = i_rx_in.first; // RULE_08 RULE_17
      end
    end else begin
      pins_nxt.ser = 1'b0; // RULE_15
      if (load) begin
        nib_raw_nxt = {sh_r, i_rx_in.data};
        pins_nxt.tclk = 1'b0; // RULE_06
        pins_nxt.frame = (idx_r == NIB_IDX_RST); // RULE_09 RULE_17
      end else if (rise && phase_r == PHASE_CLK_HIGH && !i_rx_in.first) begin
        pins_nxt.tclk = 1'b1; // RULE_04
      end
    end
    pins_nxt.nib = nib_raw_nxt;
    if (i_hdlc_enable) begin
      pins_nxt.nib[HDLC_NIB_BIT] = i_hdlc_byte[HDLC_NIB_BIT]; // RULE_16
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pins_r <= PINS_RST;
      nib_raw_r <= '0;
    end else begin
      pins_r <= pins_nxt;
      nib_raw_r <= nib_raw_nxt;
    end
  end

  assign o_rx_terminal_clock = pins_r.tclk;
  assign o_rx_serial_payload = pins_r.ser;
  assign o_rx_payload_nibble = pins_r.nib;
  assign o_rx_frame_boundary = pins_r.frame;
  assign o_loop_timing_clock_out = pins_r.loop;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic ser_mode_2;
  logic nib_mode_2;
  assign ser_mode_2 = !nib_s && !nib_d_r;
  assign nib_mode_2 = nib_s && nib_d_r;

  a_serial_clk_rate: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_01
    ser_mode_2 && rise |=> pins_r.tclk ##1 (pins_r.tclk || $past(fall)))
    else $error("serial terminal clock not following line clock");

  a_serial_data_rise: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_02
    $past(ser_mode_2) && $changed(pins_r.ser) |-> $rose(pins_r.tclk))
    else $error("serial data changed off the clock rise");

  a_nibble_data_fall: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_06
    $past(nib_mode_2) && $changed(nib_raw_r) |-> $fell(pins_r.tclk))
    else $error("nibble data changed off the clock fall");

  a_nibble_clk_derived: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_04
    $past(nib_mode_2) && $rose(pins_r.tclk) |-> $past(rise) && $past(phase_r) == PHASE_CLK_HIGH)
    else $error("nibble clock rose without a line clock edge");

  a_nib_count_wrap: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_05
    load && idx_r == limit - 11'h001 |=> idx_r == NIB_IDX_RST)
    else $error("nibble count did not wrap at frame length");

  a_nib_idx_bound: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_05
    nib_mode_2 |-> idx_r < limit)
    else $error("nibble index beyond frame length");

  a_serial_frame_mark: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_08
    ser_mode_2 && rise && i_rx_in.first |=> pins_r.frame && $rose(pins_r.tclk))
    else $error("serial frame marker missing at first bit");

  a_frame_with_data: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_17
    $past(nib_mode_2) && $changed(pins_r.frame) |-> $fell(pins_r.tclk))
    else $error("nibble frame marker moved off the data edge");

  a_serial_gated: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_15
    nib_s |=> !pins_r.ser)
    else $error("serial output live in nibble mode");

  a_loop_clk_copy: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_13
    !i_hdlc_enable |=> pins_r.loop == $past(line_s))
    else $error("loop clock is not the line clock");

  a_loop_hdlc_bit7: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_14
    i_hdlc_enable |=> pins_r.loop == $past(i_hdlc_byte[HDLC_LOOP_BIT]))
    else $error("hdlc bit 7 missing on loop pin");

  a_nib0_hdlc_bit0: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_16
    i_hdlc_enable |=> pins_r.nib[HDLC_NIB_BIT] == $past(i_hdlc_byte[HDLC_NIB_BIT]))
    else $error("hdlc bit 0 missing on nibble pin");

  a_tx_capture_rise: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_12
    rise && i_loop_timing |=> tx_vld_r && tx_bit_r == $past(tx_d_r))
    else $error("tx bit not captured on loop clock rise");

  // marker follows the index of the nibble being loaded, so a wrap marks the next load
  a_nibble_frame_mark: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_09
    nib_mode_2 && load && idx_r == NIB_IDX_RST |=> pins_r.frame)
    else $error("nibble frame marker missing at first nibble");

  a_nibble_frame_clear: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_09
    nib_mode_2 && load && idx_r != NIB_IDX_RST |=> !pins_r.frame)
    else $error("nibble frame marker longer than one nibble");

  a_serial_frame_clear: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_08
    ser_mode_2 && rise && !i_rx_in.first |=> !pins_r.frame)
    else $error("serial frame marker longer than one bit");

  a_serial_data_hold: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_02
    ser_mode_2 && !rise |=> $stable(pins_r.ser) && $stable(pins_r.frame))
    else $error("serial data moved without a line clock rise");

  a_nibble_data_hold: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_06
    nib_mode_2 && !load |=> $stable(nib_raw_r) && $stable(pins_r.frame))
    else $error("nibble data moved without a load");

  a_nibble_load_fall: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_06
    nib_mode_2 && load |=> !pins_r.tclk)
    else $error("nibble clock not low after a load");

  a_tx_single_pulse: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_12
    tx_vld_r |=> !tx_vld_r)
    else $error("tx valid longer than one cycle");

  a_tx_idle_hold: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_12
    !(rise && i_loop_timing) |=> !tx_vld_r && $stable(tx_bit_r))
    else $error("tx bit captured off the loop clock rise");

  a_first_restart: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_05
    nib_mode_2 && rise && i_rx_in.first |=> phase_r == 2'h1 && idx_r == NIB_IDX_RST)
    else $error("first bit did not restart the nibble count");

  a_mode_change_reset: assert property (@(posedge i_clock) disable iff (i_rst) // RULE_15
    nib_s != nib_d_r |=> phase_r == PHASE_RST && idx_r == NIB_IDX_RST)
    else $error("mode change left nibble state behind");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------

  c_serial_frame: cover property (@(posedge i_clock) disable iff (i_rst)
    ser_mode_2 && pins_r.frame && $rose(pins_r.tclk));
  c_nibble_frame: cover property (@(posedge i_clock) disable iff (i_rst)
    nib_mode_2 && $rose(pins_r.frame));
  c_tx_capture: cover property (@(posedge i_clock) disable iff (i_rst)
    tx_vld_r);
  c_hdlc_on: cover property (@(posedge i_clock) disable iff (i_rst)
    i_hdlc_enable && nib_mode_2 && load);
  c_nib_wrap: cover property (@(posedge i_clock) disable iff (i_rst)
    nib_mode_2 && load && idx_r == limit - 11'h001);

endmodule // rto_rx_terminal

// File: testbench/rto_term_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// terminal equipment on the payload pins
// ----------------------------------------------------------------
module rto_term_model
  import rto_pkg::*;
(
  input wire logic i_nib_mode, // 1 nibble, 0 serial
  input wire rto_pins_s i_pins, // device output pins
  output logic o_tx, // tx serial pin
  output logic o_got, // toggles per sample
  output logic [5:0] o_word, // {frame, ser, nib}
  output logic [11:0] o_pulses, // clock rises per frame
  output logic o_tx_got // toggles per tx launch
);
  logic [11:0] cnt = 12'h000;
  logic [15:0] lfsr = 16'hACE1;
  initial begin
    o_tx = 1'b0;
    o_got = 1'b0;
    o_word = 6'h00;
    o_pulses = 12'h000;
    o_tx_got = 1'b0;
  end
  always @(negedge i_pins.tclk) begin
    if (!i_nib_mode) begin
      o_word <= {i_pins.frame, i_pins.ser, i_pins.nib};
      o_got <= ~o_got;
    end
  end
  // o_got goes last so a watcher sees word and count settled
  always @(posedge i_pins.tclk) begin
    if (i_nib_mode) begin
      cnt = cnt + 12'h001;
      if (i_pins.frame) begin
        o_pulses <= cnt;
        cnt = 12'h000;
      end
      o_word <= {i_pins.frame, i_pins.ser, i_pins.nib};
      o_got <= ~o_got;
    end
  end
  always @(posedge i_pins.loop) begin
    #1;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    o_tx = lfsr[0];
    o_tx_got = ~o_tx_got;
  end
endmodule // rto_term_model

// File: testbench/rto_rx_terminal_bench.sv
`timescale 1ns/1ns
module rto_rx_terminal_bench
  import rto_pkg::*;
();
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic line_clk = 1'b0;
  logic nib_sel = 1'b0;
  logic loop_on = 1'b0;
  logic hdlc_on = 1'b0;
  logic [7:0] hdlc_byte = 8'h00;
  rto_fmt_e fmt = RTO_FMT_DS3;
  rto_bit_s rx_in = '0;
  wire rto_pins_s pins;
  logic take, tx_pin, tx_bit, tx_vld, got, tx_got;
  logic [5:0] word;
  logic [11:0] pulses;
  logic [31:0] rnd;
  logic [5:0] exp_q[$];
  logic tx_q[$];
  logic chk_on = 1'b0, cnt_ok = 1'b0, restart = 1'b0, arm = 1'b0, acc_first = 1'b0;
  logic [3:0] acc = 4'h0;
  int n_mismatch = 0, compares = 0, seed = 32'h5a39;
  int frame_len = 16, idx = 0, n_line = 0, n_tclk = 0, n_loop = 0;
  rto_fmt_e fmts[3] = '{RTO_FMT_DS3, RTO_FMT_E3_G832, RTO_FMT_E3_G751};
  int lens[3] = '{32, 40, 4 * int'(NIB_PER_FRAME_G751)};

  always #5 i_clock = ~i_clock;
  // line clock edges kept off both clock edges, period 125 ns
  initial begin
    #2;
    forever begin
      line_clk = 1'b1;
      #62;
      line_clk = 1'b0;
      #63;
    end
  end
  always @(posedge line_clk) n_line++;
  always @(posedge pins.tclk) n_tclk++;
  always @(posedge pins.loop) n_loop++;

  rto_rx_terminal rto_rx_terminal_inst (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_recovered_line_clock(line_clk),
    .i_nibble_interface_select(nib_sel),
    .i_tx_serial_payload(tx_pin),
    .i_frame_format(fmt),
    .i_loop_timing(loop_on),
    .i_hdlc_enable(hdlc_on),
    .i_hdlc_byte(hdlc_byte),
    .i_rx_in(rx_in),
    .o_bit_take(take),
    .o_rx_terminal_clock(pins.tclk),
    .o_rx_serial_payload(pins.ser),
    .o_rx_payload_nibble(pins.nib),
    .o_rx_frame_boundary(pins.frame),
    .o_loop_timing_clock_out(pins.loop),
    .o_tx_bit(tx_bit),
    .o_tx_bit_valid(tx_vld)
  );
  rto_term_model rto_term_model_inst (
    .i_nib_mode(nib_sel),
    .i_pins(pins),
    .o_tx(tx_pin),
    .o_got(got),
    .o_word(word),
    .o_pulses(pulses),
    .o_tx_got(tx_got)
  );

  // ----------------------------------------------------------------
  // compares and closing
  // ----------------------------------------------------------------
  task automatic cmp_bits(input logic [5:0] got_v, input logic [5:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic cmp_count(input logic [11:0] got_v, input logic [11:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_take;
    for (int k = 0; k < 40; k++) begin
      @(negedge i_clock);
      if (take === 1'b1) return;
    end
    cmp_bits({5'h00, take}, 6'h01);
    stop_test;
  endtask
  task automatic start_run(input logic nib, input rto_fmt_e f, input int bits);
    chk_on = 1'b0;
    nib_sel = nib;
    fmt = f;
    frame_len = bits;
    repeat (8) wait_take;
    restart = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // payload driver and result watchers
  // ----------------------------------------------------------------
  // checking starts where no older unit is still in flight
  always @(negedge i_clock) begin
    if (take === 1'b1) begin
      rnd = $random(seed);
      if (restart) begin
        idx = 0;
        restart = 1'b0;
        arm = 1'b1;
      end
      rx_in.first = (idx == 0);
      rx_in.data = rnd[0];
      acc = {acc[2:0], rnd[0]};
      if (idx % 4 == 0) acc_first = rx_in.first;
      if (arm && (!nib_sel || idx % 4 == 3)) begin
        exp_q.delete();
        chk_on = 1'b1;
        cnt_ok = 1'b0;
        arm = 1'b0;
      end
      if (!nib_sel) exp_q.push_back({rx_in.first, rnd[0], 4'h0});
      else if (idx % 4 == 3) exp_q.push_back({acc_first, 1'b0, acc});
      idx = (idx + 1) % frame_len;
    end
  end
  always @(got) begin
    #1;
    if (chk_on) begin
      cmp_bits(word, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      if (nib_sel && word[5]) begin
        if (cnt_ok) cmp_count(pulses, 12'(frame_len / 4));
        cnt_ok = 1'b1;
      end
    end
  end
  always @(tx_got) tx_q.push_back(tx_pin);
  always @(negedge i_clock) begin
    if (tx_vld === 1'b1) cmp_bits({5'h00, tx_bit}, {5'h00, tx_q.size() > 0 ? tx_q.pop_front() : 1'bx});
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int nl, nt, no, nc;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    nc = compares;
    start_run(1'b0, RTO_FMT_DS3, 24);
    repeat (30) wait_take;
    loop_on = 1'b1;
    tx_q = tx_q[$:$];
    nl = n_line;
    nt = n_tclk;
    no = n_loop;
    repeat (40) wait_take;
    cmp_count(12'(n_tclk - nt), 12'(n_line - nl));
    cmp_count(12'(n_loop - no), 12'(n_line - nl));
    cmp_count({11'h000, (compares - nc) >= 60}, 12'h001);
    loop_on = 1'b0;
    $display("test serial and loop timing done");
    for (int i = 0; i < 3; i++) begin
      nc = compares;
      start_run(1'b1, fmts[i], lens[i]);
      repeat (2 * lens[i] + 40) wait_take;
      cmp_count({11'h000, (compares - nc) >= lens[i] / 2}, 12'h001);
      $display("test nibble format %0d done", i);
    end
    chk_on = 1'b0;
    hdlc_on = 1'b1;
    repeat (4) begin
      hdlc_byte = 8'($random(seed));
      repeat (3) @(negedge i_clock);
      cmp_bits({4'h0, pins.loop, pins.nib[0]}, {4'h0, hdlc_byte[7], hdlc_byte[0]});
    end
    $display("test hdlc pins done");
    stop_test;
  end
endmodule // rto_rx_terminal_bench
